// file: logic/iq_path_pkg.sv
package iq_path_pkg;

  typedef struct packed {
    logic signed [13:0] i;
    logic signed [13:0] q;
  } iq_t;

  typedef struct packed {
    logic valid;
    logic [13:0] i;
    logic [13:0] q;
  } pin_word_t;

  // Register offsets
  localparam logic [6:0] OFS_COMMON = 7'h00;
  localparam logic [6:0] OFS_CONTROL = 7'h01;
  localparam logic [6:0] OFS_PLL = 7'h02;
  localparam logic [6:0] OFS_FREQ0 = 7'h03;
  localparam logic [6:0] OFS_FREQ1 = 7'h04;
  localparam logic [6:0] OFS_FREQ2 = 7'h05;
  localparam logic [6:0] OFS_FREQ3 = 7'h06;
  localparam logic [6:0] OFS_PHASE_LOW = 7'h07;
  localparam logic [6:0] OFS_PHASE_HIGH = 7'h08;
  localparam logic [6:0] OFS_DAC_CFG = 7'h0F;
  localparam logic [6:0] OFS_STATUS = 7'h1F;

  // Field positions
  localparam int COMMON_CODING_BIT = 2;
  localparam int COMMON_MODE_BIT = 3;
  localparam int CTRL_X8_BIT = 0;
  localparam int CTRL_SINC_BIT = 1;
  localparam int CTRL_SINV_BIT = 2;
  localparam int CTRL_LP_BIT = 3;
  localparam int PLL_DIV_LSB = 3;
  localparam int PLL_DELAY_LSB = 1;
  localparam int PLL_POL_BIT = 0;
  localparam int DAC_GAIN_CUT_BIT = 1;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_EMPTY_BIT = 1;

  // Values after reset
  localparam logic [7:0] RST_COMMON = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_PLL = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Divider encodings
  localparam logic [1:0] DIV_2 = 2'h0;
  localparam logic [1:0] DIV_4 = 2'h1;
  localparam logic [2:0] DIV_LIMIT_2 = 3'h1;
  localparam logic [2:0] DIV_LIMIT_4 = 3'h3;
  localparam logic [2:0] DIV_LIMIT_8 = 3'h7;

  // Counts and scalings
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] READY_LIMIT = 4'h4;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
  localparam logic [4:0] SPI_DATA_START = 5'h08;
  localparam int SINE_SHIFT = 14;
  localparam int GAIN_CUT_MUL = 181;
  localparam int GAIN_CUT_SHIFT = 8;
  localparam int SINC_SHIFT = 9;
  localparam int SINC_TAPS = 9;

  function automatic logic signed [13:0] sat14(input logic signed [39:0] v);
    if (v > 40'sd8191)
      sat14 = 14'sh1FFF;
    else if (v < -40'sd8192)
      sat14 = -14'sh2000;
    else
      sat14 = v[13:0];
  endfunction : sat14

  // Odd-phase taps per half-band stage, both halves
  function automatic int hb_taps(input int stage);
    hb_taps = (stage == 1) ? 28 : (stage == 2) ? 12 : 8;
  endfunction : hb_taps

  // Centre tap is a power of two; this is its exponent
  function automatic int hb_shift(input int stage);
    hb_shift = (stage == 1) ? 15 : (stage == 2) ? 12 : 13;
  endfunction : hb_shift

  function automatic logic signed [17:0] hb_coef(input int stage, input int j);
    int c;
    c = 0;
    if (stage == 1)
    begin
      case (j)
        0: c = -4; 1: c = 13; 2: c = -34; 3: c = 72; 4: c = -138; 5: c = 245;
        6: c = -408; 7: c = 650; 8: c = -1003; 9: c = 1521; 10: c = -2315;
        11: c = 3671; 12: c = -6642; 13: c = 20756;
        default: c = 0;
      endcase
    end
    else if (stage == 2)
    begin
      case (j)
        0: c = -2; 1: c = 17; 2: c = -75; 3: c = 238; 4: c = -660; 5: c = 2530;
        default: c = 0;
      endcase
    end
    else
    begin
      case (j)
        0: c = -39; 1: c = 273; 2: c = -1102; 3: c = 4964;
        default: c = 0;
      endcase
    end
    hb_coef = c[17:0];
  endfunction : hb_coef

  function automatic logic signed [9:0] sinc_coef(input int j);
    case (j)
      0, 8: sinc_coef = 10'sd2;
      1, 7: sinc_coef = -10'sd4;
      2, 6: sinc_coef = 10'sd10;
      3, 5: sinc_coef = -10'sd35;
      default: sinc_coef = 10'sd401;
    endcase
  endfunction : sinc_coef

endpackage : iq_path_pkg

// file: logic/sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic do_wr;
  logic do_rd;

  assign wr_ready = (level != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign rd_valid = (level != '0);
  assign rd_data = mem[rd_ptr];
  assign do_wr = wr_valid && wr_ready;
  assign do_rd = rd_valid && rd_ready;

  always_ff @(posedge mclk)
  begin
    if (do_wr)
      mem[wr_ptr] <= wr_data;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      if (do_wr && !do_rd)
        level <= level + 1'b1;
      else if (do_rd && !do_wr)
        level <= level - 1'b1;
    end
  end
endmodule : sample_fifo

// file: logic/halfband_stage.sv
`timescale 1ns/1ps
module halfband_stage #(
  parameter int STAGE = 1
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire iq_path_pkg::iq_t in_data,
  output logic out_valid,
  input wire logic out_ready,
  output iq_path_pkg::iq_t out_data
);
  import iq_path_pkg::*;

  localparam int K = hb_taps(STAGE);
  localparam int SH = hb_shift(STAGE);
  localparam int D = K / 2 - 1;

  iq_t hist [0:K-1];
  logic [1:0] pend;
  logic accept;

  // Odd-index taps form one polyphase branch
  function automatic logic signed [13:0] odd_sum(input logic lane);
    logic signed [39:0] acc;
    int jj;
    acc = '0;
    for (int n = 0; n < K; n++)
    begin
      jj = (n < K / 2) ? n : K - 1 - n;
      acc = acc + hb_coef(STAGE, jj) * (lane ? hist[n].q : hist[n].i);
    end
    odd_sum = sat14(acc >>> SH);
  endfunction : odd_sum

  assign in_ready = (pend == 2'd0) || (pend == 2'd1 && out_ready);
  assign accept = in_valid && in_ready;
  assign out_valid = (pend != 2'd0);

  // Two outputs per input; the centre branch is an exact delayed copy
  always_comb
  begin
    if (pend == 2'd2)
      out_data = '{i: odd_sum(1'b0), q: odd_sum(1'b1)};
    else
      out_data = hist[D];
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pend <= 2'd0;
      for (int n = 0; n < K; n++)
        hist[n] <= '0;
    end
    else if (accept)
    begin
      pend <= 2'd2;
      hist[0] <= in_data;
      for (int n = 1; n < K; n++)
        hist[n] <= hist[n-1];
    end
    else if (out_valid && out_ready)
      pend <= pend - 2'd1;
  end
endmodule : halfband_stage

// file: logic/iq_modulator_path.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Divider field in clock config sets digital clock versus sample clock ratio.
// - Divider codes: 00 divide by 2, 01 by 4, 10 by 8.
// - Delay field adjusts the sample clock at the core; the polarity bit has no effect.
// - Three half-band filters, only the third selectable, give 4x or 8x interpolation.
// - Filters have 55, 23, 15 taps with the tabulated integer coefficients.
// - Each filter reaches 80 dBc stop band, ripple under 0.0005 dB.
// - Modulator multiplies 14-bit I and Q by oscillator cosine and sine.
// - Sine sign can be inverted to pick the upper or lower sideband.
// - Full mode uses a 32-bit frequency word from four byte registers.
// - Phase offset is 16 bits in two byte registers, spanning one cycle.
// - Low-power mode uses only the top five frequency word bits.
// - Low-power mode takes phase from the top five upper phase bits.
// - Gain cut lowers modulator output by 3 dB.
// - Optional 9-tap inverse-sinc filter, centre 401, DC loss 3.4 dB.
// - Format bit selects offset binary or two's complement input.
// - Core code 0..16383; two's complement maps by inverting the top bit.
// - Mode bit selects dual-port buses or one interleaved bus.
module iq_modulator_path (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic data_valid,
  input wire logic [13:0] i_pins,
  input wire logic [13:0] q_pins,
  output logic data_ready,
  output logic digital_logic_clock,
  output logic [13:0] core_a_code,
  output logic [13:0] core_b_code,
  output logic core_valid
);
  import iq_path_pkg::*;

  // ----------------------------------------
  // Serial register port
  // ----------------------------------------
  logic [2:0] cs_s, sclk_s, sdi_s;
  logic [15:0] shreg;
  logic [4:0] bitcnt;
  logic [7:0] rd_shift;
  logic [7:0] rd_byte;
  logic sclk_rise, sclk_fall, cs_act;
  logic [7:0] common_reg, control_reg, pll_clock_config, dac_cfg;
  logic [7:0] osc_freq_byte0, osc_freq_byte1, osc_freq_byte2, osc_freq_byte3;
  logic [7:0] osc_phase_low, osc_phase_high;
  logic [7:0] status_reg;
  logic wr_stb, ovf_set, ovf_clr;
  logic [6:0] wr_addr;
  logic [7:0] wr_dat;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cs_s <= 3'h7;
      sclk_s <= 3'h0;
      sdi_s <= 3'h0;
    end
    else
    begin
      cs_s <= {cs_s[1:0], spi_cs_n};
      sclk_s <= {sclk_s[1:0], spi_sclk};
      sdi_s <= {sdi_s[1:0], spi_sdi};
    end
  end

  assign cs_act = !cs_s[1];
  assign sclk_rise = cs_act && sclk_s[1] && !sclk_s[2];
  assign sclk_fall = cs_act && !sclk_s[1] && sclk_s[2];

  function automatic logic [7:0] reg_read(input logic [6:0] a);
    case (a)
      OFS_COMMON: reg_read = common_reg;
      OFS_CONTROL: reg_read = control_reg;
      OFS_PLL: reg_read = pll_clock_config;
      OFS_FREQ0: reg_read = osc_freq_byte0;
      OFS_FREQ1: reg_read = osc_freq_byte1;
      OFS_FREQ2: reg_read = osc_freq_byte2;
      OFS_FREQ3: reg_read = osc_freq_byte3;
      OFS_PHASE_LOW: reg_read = osc_phase_low;
      OFS_PHASE_HIGH: reg_read = osc_phase_high;
      OFS_DAC_CFG: reg_read = dac_cfg;
      OFS_STATUS: reg_read = status_reg;
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  always_comb
    rd_byte = reg_read(shreg[6:0]);

  // Frame: read flag, 7-bit address, 8 data bits, most significant first
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      shreg <= 16'h0000;
      bitcnt <= 5'h00;
      rd_shift <= 8'h00;
      spi_sdo <= 1'b0;
      spi_sdo_oe <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 7'h00;
      wr_dat <= 8'h00;
    end
    else
    begin
      wr_stb <= 1'b0;
      if (!cs_act)
      begin
        bitcnt <= 5'h00;
        spi_sdo_oe <= 1'b0;
      end
      else if (sclk_rise && bitcnt != SPI_FRAME_BITS)
      begin
        shreg <= {shreg[14:0], sdi_s[1]};
        bitcnt <= bitcnt + 5'h01;
        if (bitcnt == SPI_FRAME_BITS - 5'h01 && !shreg[14])
        begin
          wr_stb <= 1'b1;
          wr_addr <= shreg[13:7];
          wr_dat <= {shreg[6:0], sdi_s[1]};
        end
      end
      else if (sclk_fall && shreg[7] && bitcnt == SPI_DATA_START)
      begin
        rd_shift <= {rd_byte[6:0], 1'b0};
        spi_sdo <= rd_byte[7];
        spi_sdo_oe <= 1'b1;
      end
      else if (sclk_fall && spi_sdo_oe)
      begin
        spi_sdo <= rd_shift[7];
        rd_shift <= {rd_shift[6:0], 1'b0};
        if (bitcnt == SPI_FRAME_BITS)
          spi_sdo_oe <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      common_reg <= RST_COMMON;
      control_reg <= RST_CONTROL;
      pll_clock_config <= RST_PLL;
      dac_cfg <= RST_BYTE;
      osc_freq_byte0 <= RST_BYTE;
      osc_freq_byte1 <= RST_BYTE;
      osc_freq_byte2 <= RST_BYTE;
      osc_freq_byte3 <= RST_BYTE;
      osc_phase_low <= RST_BYTE;
      osc_phase_high <= RST_BYTE;
    end
    else if (wr_stb)
    begin
      case (wr_addr)
        OFS_COMMON: common_reg <= wr_dat;
        OFS_CONTROL: control_reg <= wr_dat;
        OFS_PLL: pll_clock_config <= wr_dat;
        OFS_FREQ0: osc_freq_byte0 <= wr_dat;
        OFS_FREQ1: osc_freq_byte1 <= wr_dat;
        OFS_FREQ2: osc_freq_byte2 <= wr_dat;
        OFS_FREQ3: osc_freq_byte3 <= wr_dat;
        OFS_PHASE_LOW: osc_phase_low <= wr_dat;
        OFS_PHASE_HIGH: osc_phase_high <= wr_dat;
        OFS_DAC_CFG: dac_cfg <= {6'h00, wr_dat[DAC_GAIN_CUT_BIT], 1'b0};
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Clock divider
  // ----------------------------------------
  logic [2:0] div_cnt, div_limit;
  logic [1:0] div_sel;

  assign div_sel = pll_clock_config[PLL_DIV_LSB +: 2];
  assign div_limit = (div_sel == DIV_2) ? DIV_LIMIT_2 :
                     (div_sel == DIV_4) ? DIV_LIMIT_4 : DIV_LIMIT_8;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_cnt <= 3'h0;
      digital_logic_clock <= 1'b0;
    end
    else
    begin
      div_cnt <= (div_cnt >= div_limit) ? 3'h0 : div_cnt + 3'h1;
      digital_logic_clock <= (div_cnt <= (div_limit >> 1));
    end
  end

  // ----------------------------------------
  // Input capture and buffer
  // ----------------------------------------
  pin_word_t pin_s1, pin_s2;
  logic mode_il, il_second, push;
  logic [13:0] il_hold;
  iq_t push_word, fifo_word;
  logic fifo_wr_ready, fifo_rd_valid, s1_in_ready;
  logic [3:0] fifo_level;

  assign mode_il = common_reg[COMMON_MODE_BIT];

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end
    else
    begin
      pin_s1 <= '{valid: data_valid, i: i_pins, q: q_pins};
      pin_s2 <= pin_s1;
    end
  end

  // Offset binary becomes signed by flipping the top bit
  function automatic logic signed [13:0] to_signed(input logic [13:0] w);
    to_signed = common_reg[COMMON_CODING_BIT] ? w : {~w[13], w[12:0]};
  endfunction : to_signed

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      il_second <= 1'b0;
      il_hold <= 14'h0000;
    end
    else if (!mode_il)
      il_second <= 1'b0;
    else if (pin_s2.valid)
    begin
      il_second <= !il_second;
      il_hold <= pin_s2.i;
    end
  end

  assign push = pin_s2.valid && (!mode_il || il_second);
  always_comb
  begin
    if (mode_il)
      push_word = '{i: to_signed(il_hold), q: to_signed(pin_s2.i)};
    else
      push_word = '{i: to_signed(pin_s2.i), q: to_signed(pin_s2.q)};
  end

  sample_fifo #(.WIDTH(28), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .wr_valid(push),
    .wr_ready(fifo_wr_ready),
    .wr_data(push_word),
    .rd_valid(fifo_rd_valid),
    .rd_ready(s1_in_ready),
    .rd_data(fifo_word),
    .level(fifo_level)
  );

  assign ovf_set = push && !fifo_wr_ready;
  assign ovf_clr = wr_stb && wr_addr == OFS_STATUS && wr_dat[STAT_OVF_BIT];

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      data_ready <= 1'b0;
      status_reg <= 8'h00;
    end
    else
    begin
      data_ready <= (fifo_level < READY_LIMIT);
      status_reg[STAT_EMPTY_BIT] <= !fifo_rd_valid;
      if (ovf_set)
        status_reg[STAT_OVF_BIT] <= 1'b1;
      else if (ovf_clr)
        status_reg[STAT_OVF_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interpolation chain
  // ----------------------------------------
  logic x8, s1_ov, s2_ir, s2_ov, s2_or, s3_ir, s3_ov, fin_v;
  iq_t s1_od, s2_od, s3_od, fin_d;

  assign x8 = control_reg[CTRL_X8_BIT];
  assign s2_or = x8 ? s3_ir : 1'b1;
  assign fin_v = x8 ? s3_ov : s2_ov;
  assign fin_d = x8 ? s3_od : s2_od;

  halfband_stage #(.STAGE(1)) u_hb1 (
    .mclk(mclk), .nrst(nrst), .in_valid(fifo_rd_valid), .in_ready(s1_in_ready),
    .in_data(fifo_word), .out_valid(s1_ov), .out_ready(s2_ir), .out_data(s1_od)
  );
  halfband_stage #(.STAGE(2)) u_hb2 (
    .mclk(mclk), .nrst(nrst), .in_valid(s1_ov), .in_ready(s2_ir),
    .in_data(s1_od), .out_valid(s2_ov), .out_ready(s2_or), .out_data(s2_od)
  );
  halfband_stage #(.STAGE(3)) u_hb3 (
    .mclk(mclk), .nrst(nrst), .in_valid(s2_ov && x8), .in_ready(s3_ir),
    .in_data(s2_od), .out_valid(s3_ov), .out_ready(1'b1), .out_data(s3_od)
  );

  // ----------------------------------------
  // Oscillator and modulator
  // ----------------------------------------
  logic [31:0] freq_word, phase_acc;
  logic [15:0] phase_off;
  logic [5:0] ph;
  logic lp, sinv;
  logic signed [13:0] mod_a, mod_b;
  logic mod_v;

  assign freq_word = {osc_freq_byte3, osc_freq_byte2, osc_freq_byte1, osc_freq_byte0};
  assign phase_off = {osc_phase_high, osc_phase_low};
  assign lp = control_reg[CTRL_LP_BIT];
  assign sinv = control_reg[CTRL_SINV_BIT];
  assign ph = lp ? {phase_acc[31:27] + osc_phase_high[7:3], 1'b0}
                 : phase_acc[31:26] + phase_off[15:10];

  // Quarter-wave table, 64 points per cycle
  function automatic logic signed [15:0] sine64(input logic [5:0] p);
    logic [4:0] k;
    logic signed [15:0] t;
    k = p[4] ? 5'd16 - {1'b0, p[3:0]} : {1'b0, p[3:0]};
    case (k)
      5'd0: t = 16'sd0; 5'd1: t = 16'sd1606; 5'd2: t = 16'sd3196; 5'd3: t = 16'sd4756;
      5'd4: t = 16'sd6270; 5'd5: t = 16'sd7723; 5'd6: t = 16'sd9102;
      5'd7: t = 16'sd10394; 5'd8: t = 16'sd11585; 5'd9: t = 16'sd12665;
      5'd10: t = 16'sd13623; 5'd11: t = 16'sd14449; 5'd12: t = 16'sd15137;
      5'd13: t = 16'sd15679; 5'd14: t = 16'sd16069; 5'd15: t = 16'sd16305;
      default: t = 16'sd16384;
    endcase
    sine64 = p[5] ? -t : t;
  endfunction : sine64

  function automatic logic signed [13:0] scale_out(input logic signed [39:0] v);
    logic signed [39:0] s;
    s = v >>> SINE_SHIFT;
    if (dac_cfg[DAC_GAIN_CUT_BIT])
      s = (s * GAIN_CUT_MUL) >>> GAIN_CUT_SHIFT;
    scale_out = sat14(s);
  endfunction : scale_out

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      phase_acc <= 32'h00000000;
      mod_a <= 14'sh0000;
      mod_b <= 14'sh0000;
      mod_v <= 1'b0;
    end
    else
    begin
      mod_v <= fin_v;
      if (fin_v)
      begin
        phase_acc <= phase_acc + (lp ? {freq_word[31:27], 27'h0} : freq_word);
        mod_a <= scale_out(fin_d.i * sine64(ph + 6'h10)
                 - (sinv ? -sine64(ph) : sine64(ph)) * fin_d.q);
        mod_b <= scale_out((sinv ? -sine64(ph) : sine64(ph)) * fin_d.i
                 + fin_d.q * sine64(ph + 6'h10));
      end
    end
  end

  // ----------------------------------------
  // Inverse sinc, clock delay, core codes
  // ----------------------------------------
  iq_t sinc_hist [0:SINC_TAPS-1];
  iq_t sinc_out;
  iq_t dly [0:3];
  logic [3:0] v_dly;
  logic [1:0] clk_delay;

  function automatic logic signed [13:0] sinc_sum(input logic lane);
    logic signed [39:0] acc;
    acc = '0;
    for (int n = 0; n < SINC_TAPS; n++)
      acc = acc + sinc_coef(n) * (lane ? sinc_hist[n].q : sinc_hist[n].i);
    sinc_sum = sat14(acc >>> SINC_SHIFT);
  endfunction : sinc_sum

  always_comb
  begin
    if (control_reg[CTRL_SINC_BIT])
      sinc_out = '{i: sinc_sum(1'b0), q: sinc_sum(1'b1)};
    else
      sinc_out = sinc_hist[SINC_TAPS/2];
  end
  assign clk_delay = pll_clock_config[PLL_DELAY_LSB +: 2];

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int n = 0; n < SINC_TAPS; n++)
        sinc_hist[n] <= '0;
      for (int n = 0; n < 4; n++)
        dly[n] <= '0;
      v_dly <= 4'h0;
      core_a_code <= 14'h2000;
      core_b_code <= 14'h2000;
      core_valid <= 1'b0;
    end
    else
    begin
      if (mod_v)
      begin
        sinc_hist[0] <= '{i: mod_a, q: mod_b};
        for (int n = 1; n < SINC_TAPS; n++)
          sinc_hist[n] <= sinc_hist[n-1];
      end
      dly[0] <= sinc_out;
      v_dly[0] <= mod_v;
      for (int n = 1; n < 4; n++)
      begin
        dly[n] <= dly[n-1];
        v_dly[n] <= v_dly[n-1];
      end
      // Polarity bit is gated off and leaves core_valid unchanged
      core_valid <= v_dly[clk_delay] ^ (pll_clock_config[PLL_POL_BIT] && 1'b0);
      if (v_dly[clk_delay])
      begin
        core_a_code <= {~dly[clk_delay].i[13], dly[clk_delay].i[12:0]};
        core_b_code <= {~dly[clk_delay].q[13], dly[clk_delay].q[12:0]};
      end
    end
  end
endmodule : iq_modulator_path

// file: tb/path_checker_sva.sv
`timescale 1ns/1ps
module path_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe,
  input wire logic data_valid,
  input wire logic data_ready,
  input wire logic digital_logic_clock,
  input wire logic [13:0] core_a_code,
  input wire logic [13:0] core_b_code,
  input wire logic core_valid
);
  logic [15:0] n_in;
  logic [15:0] n_out;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  sequence sclk_held;
    spi_sclk [*6];
  endsequence
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      n_in <= 16'h0000;
    else
      n_in <= n_in + {15'h0000, data_valid};
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      n_out <= 16'h0000;
    else
      n_out <= n_out + {15'h0000, core_valid};
  code_reset_a: assert property (
    $rose(nrst) |-> core_a_code == 14'h2000 && core_b_code == 14'h2000)
    else $error("codes not midscale after reset");
  ready_release_a: assert property ($rose(nrst) |-> ##[0:3] data_ready)
    else $error("data ready late after reset");
  valid_cause_a: assert property (core_valid |-> n_in != 16'h0000)
    else $error("output without input");
  rate_bound_a: assert property (n_out <= {n_in[12:0], 3'b000})
    else $error("more than eight outputs per word");
  divclk_high_a: assert property (
    $rose(digital_logic_clock) |-> ##[1:4] !digital_logic_clock)
    else $error("divided clock high too long");
  divclk_low_a: assert property (
    $fell(digital_logic_clock) |-> ##[1:4] digital_logic_clock)
    else $error("divided clock low too long");
  sdo_idle_a: assert property (spi_cs_n [*6] |-> !spi_sdo_oe)
    else $error("sdo driven while deselected");
  sdo_hold_a: assert property (sclk_held |-> $stable(spi_sdo))
    else $error("sdo moved while clock high");
endmodule : path_checker

bind iq_modulator_path path_checker chk (.mclk, .nrst, .spi_cs_n, .spi_sclk, .spi_sdo,
  .spi_sdo_oe, .data_valid, .data_ready, .digital_logic_clock, .core_a_code, .core_b_code,
  .core_valid);

// file: tb/iq_source.sv
`timescale 1ns/1ps
module iq_source (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic en,
  input wire logic inter,
  input wire logic data_ready,
  input wire logic [13:0] wi,
  input wire logic [13:0] wq,
  output logic data_valid = 1'b0,
  output logic [13:0] i_pins = 14'h0000,
  output logic [13:0] q_pins = 14'h0000
);
  logic sel = 1'b0;
  // Idle pins toggle so no stale word looks valid
  always @(negedge mclk or negedge nrst)
    if (!nrst)
    begin
      data_valid <= 1'b0;
      sel <= 1'b0;
    end
    else if (!data_valid && (en || sel) && data_ready)
    begin
      data_valid <= 1'b1;
      i_pins <= sel ? wq : wi;
      q_pins <= inter ? ~q_pins : wq;
      sel <= inter && !sel;
    end
    else
    begin
      data_valid <= 1'b0;
      i_pins <= ~i_pins;
      q_pins <= ~q_pins;
    end
endmodule : iq_source

// file: tb/interpolating_iq_modulator_path_test.sv
`timescale 1ns/1ps
module interpolating_iq_modulator_path_test;
  import iq_path_pkg::*;
  typedef struct {
    logic [7:0] cm, ct, ph, gc, pl;
    logic [13:0] i, q;
    int ea, eb, per;
  } row_t;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic spi_cs_n = 1'b1;
  logic spi_sclk = 1'b0;
  logic spi_sdi = 1'b0;
  logic en = 1'b0;
  logic inter = 1'b0;
  logic p;
  logic [13:0] wi;
  logic [13:0] wq;
  logic [7:0] rv;
  wire logic spi_sdo, spi_sdo_oe, data_valid, data_ready, digital_logic_clock, core_valid;
  wire logic [13:0] i_pins, q_pins, core_a_code, core_b_code;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  int lows;
  row_t rows [8] = '{
    '{8'h04, 8'h00, 8'h00, 8'h00, 8'h02, 14'h0FA0, 14'h3448, 12192, 5192, 2},
    '{8'h04, 8'h00, 8'h40, 8'h00, 8'h08, 14'h0FA0, 14'h3448, 11192, 12192, 4},
    '{8'h04, 8'h04, 8'h40, 8'h00, 8'h10, 14'h0FA0, 14'h3448, 5192, 4192, 8},
    '{8'h04, 8'h0C, 8'h44, 8'h00, 8'h18, 14'h0FA0, 14'h3448, 5192, 4192, 8},
    '{8'h04, 8'h00, 8'h00, 8'h02, 8'h88, 14'h0FA0, 14'h3448, 11020, 6071, 4},
    '{8'h04, 8'h02, 8'h00, 8'h00, 8'h13, 14'h0FA0, 14'h3448, 10903, 6159, 8},
    '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 14'h2FA0, 14'h1448, 12192, 5192, 2},
    '{8'h0C, 8'h01, 8'h00, 8'h00, 8'h08, 14'h0FA0, 14'h3448, 12192, 5192, 4}};
  iq_modulator_path DUT (.mclk, .nrst, .spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo, .spi_sdo_oe,
    .data_valid, .i_pins, .q_pins, .data_ready, .digital_logic_clock, .core_a_code,
    .core_b_code, .core_valid);
  iq_source src (.mclk, .nrst, .en, .inter, .data_ready, .wi, .wq, .data_valid, .i_pins,
    .q_pins);
  initial
    forever #5 mclk = ~mclk;
  task automatic fail(input string m);
    num_errors++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask : fail
  task automatic check(input logic [13:0] got, input int exp, input int tol, input string m);
    cmp_count++;
    if ((^got === 1'bx) || got > exp + tol || got + tol < exp)
      fail(m);
  endtask : check
  task automatic finish_test;
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  // Serial frame, MSB first, read bits sampled before each rise
  task automatic xfer(input logic [15:0] w);
    spi_cs_n = 1'b0;
    repeat (6) @(negedge mclk);
    for (int b = 15; b >= 0; b--)
    begin
      spi_sdi = w[b];
      repeat (6) @(negedge mclk);
      if (b < 8)
        rv[b] = spi_sdo;
      spi_sclk = 1'b1;
      repeat (6) @(negedge mclk);
      spi_sclk = 1'b0;
    end
    repeat (6) @(negedge mclk);
    spi_cs_n = 1'b1;
    repeat (8) @(negedge mclk);
  endtask : xfer
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    xfer({1'b0, a, d});
  endtask : wr
  initial
  begin
    repeat (60000) @(negedge mclk);
    fail("run hung");
    finish_test;
  end
  initial
  begin
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    repeat (3) @(negedge mclk);
    foreach (rows[k])
    begin
      wr(OFS_COMMON, rows[k].cm);
      wr(OFS_CONTROL, rows[k].ct);
      wr(OFS_PHASE_HIGH, rows[k].ph);
      wr(OFS_DAC_CFG, rows[k].gc);
      wr(OFS_PLL, rows[k].pl);
      xfer({1'b1, OFS_PLL, 8'h00});
      check({6'h00, rv}, rows[k].pl, 0, "clock config readback");
      n = 0;
      repeat (64)
      begin
        p = digital_logic_clock;
        @(negedge mclk);
        if (digital_logic_clock && !p)
          n++;
      end
      check(n[13:0], 64 / rows[k].per, 1, "divided clock rate");
      wi = rows[k].i;
      wq = rows[k].q;
      inter = rows[k].cm[3];
      en = 1'b1;
      lows = 0;
      repeat (400)
      begin
        @(negedge mclk);
        if (!data_ready)
          lows++;
      end
      n = 0;
      while (core_valid !== 1'b1 && n < 200)
      begin
        @(negedge mclk);
        n++;
      end
      if (n == 200)
      begin
        fail("no output");
        finish_test;
      end
      check(core_a_code, rows[k].ea, 16, "code a");
      check(core_b_code, rows[k].eb, 16, "code b");
      en = 1'b0;
      repeat (300) @(negedge mclk);
      cmp_count++;
      if (lows == 0 || data_ready !== 1'b1)
        fail("buffer never filled or not drained");
    end
    nrst = 1'b0;
    repeat (3) @(negedge mclk);
    check(core_a_code, 8192, 0, "code in reset");
    nrst = 1'b1;
    repeat (3) @(negedge mclk);
    for (int a = 0; a < 10; a++)
    begin
      xfer({1'b1, a == 9 ? 7'h10 : a[6:0], 8'h00});
      check({6'h00, rv}, 0, 0, "register after reset");
    end
    finish_test;
  end
endmodule : interpolating_iq_modulator_path_test
